// [pkg/fmc_cfg_pkg.sv]
// Constants for the flash-media configuration header slice.
// Assumes byte offsets on an 8-bit config address, dword data with byte enables.
package fmc_cfg_pkg;

  // Register byte offsets; maximum latency reuses 3eh and is placed by its lane (3)
  localparam logic [7:0] SUBSYS_OFF      = 8'h2e;
  localparam logic [7:0] CAP_PTR_OFF     = 8'h34;
  localparam logic [7:0] IRQ_LINE_OFF    = 8'h3c;
  localparam logic [7:0] IRQ_PIN_OFF     = 8'h3d;
  localparam logic [7:0] MIN_GNT_OFF     = 8'h3e;
  localparam logic [7:0] MAX_LAT_OFF     = 8'h3e;
  localparam logic [1:0] MAX_LAT_LANE    = 2'h3;
  localparam logic [7:0] SUBSYS_ACC_OFF  = 8'h50;

  // Reset and constant values
  localparam logic [15:0] SUBSYS_RST     = 16'h0000;
  localparam logic [7:0]  CAP_PTR_VAL    = 8'h44;
  localparam logic [7:0]  IRQ_LINE_RST   = 8'hff;
  localparam logic [7:0]  MIN_GNT_RST    = 8'h07;
  localparam logic [7:0]  MAX_LAT_RST    = 8'h04;

  // Interrupt pin codes, index 0 is the highest priority (A)
  localparam logic [7:0]  IRQ_PIN_A      = 8'h01;
  localparam logic [7:0]  IRQ_PIN_B      = 8'h02;
  localparam logic [7:0]  IRQ_PIN_C      = 8'h03;
  localparam logic [7:0]  IRQ_PIN_D      = 8'h04;
  localparam int          FORCE_A_BIT    = 0;

  // Tie-all bit position in the system control register
  localparam logic [7:0]  SYS_CTRL_OFF   = 8'h80;
  localparam int          TIE_ALL_BIT    = 28;

  typedef logic [7:0] fmc_byte_t;

endpackage : fmc_cfg_pkg

// [rtl/fmc_cfg_regs.sv]
// Flash-media function configuration header slice: subsystem word, capability
// pointer, interrupt line/pin, minimum grant and maximum latency.
// Assumes config cycles arrive on the core clock as single-cycle strobes, and
// that EEPROM loader, select bits and tie-all come from logic on the same clock.
module fmc_cfg_regs (
  // Clock and resets
  input  wire logic                     i_core_clk,
  input  wire logic                     i_arst_n,
  input  wire logic                     i_func_rst,
  // Configuration access port
  input  wire logic                     i_cfg_rd,
  input  wire logic                     i_cfg_wr,
  input  wire logic [7:0]               i_cfg_addr,
  input  wire logic [3:0]               i_cfg_be,
  input  wire logic [31:0]              i_cfg_wdata,
  output logic      [31:0]              o_cfg_rdata,
  output logic                          o_cfg_ack,
  // Serial EEPROM loader
  input  wire logic                     i_eep_subsys_we,
  input  wire logic [15:0]              i_eep_subsys_id,
  input  wire logic                     i_eep_max_lat_we,
  input  wire fmc_cfg_pkg::fmc_byte_t   i_eep_max_lat,
  // Internal update of minimum grant
  input  wire logic                     i_min_gnt_we,
  input  wire fmc_cfg_pkg::fmc_byte_t   i_min_gnt,
  // Interrupt routing controls
  input  wire logic [1:0]               i_int_sel,
  input  wire logic                     i_tie_all_irq_ctrl,
  // Status toward the flash-media core
  output logic      [3:0]               o_force_irq_inputs,
  output fmc_cfg_pkg::fmc_byte_t        o_irq_pin_report,
  output logic      [15:0]              o_subsys_ident_word
);
  import fmc_cfg_pkg::*;

  logic [15:0] subsys_ident_word;
  fmc_byte_t   irq_line_assignment;
  fmc_byte_t   min_burst_grant;
  fmc_byte_t   max_bus_latency;
  logic [3:0]  force_irq_inputs;
  fmc_byte_t   irq_pin_report;
  logic [31:0] next_rdata;
  logic        wr_line;
  logic        wr_subsys_acc;

  // Dword match on the config address; low two bits select lanes only
  function automatic logic dw_hit(input logic [7:0] addr, input logic [7:0] off);
    dw_hit = (addr[7:2] == off[7:2]);
  endfunction : dw_hit

  // Priority encoder over forcing inputs, A highest; select used when none
  function automatic fmc_byte_t pin_code(input logic [3:0] force_in, input logic [1:0] sel);
    if (force_in[0]) begin
      pin_code = IRQ_PIN_A;
    end else if (force_in[1]) begin
      pin_code = IRQ_PIN_B;
    end else if (force_in[2]) begin
      pin_code = IRQ_PIN_C;
    end else if (force_in[3]) begin
      pin_code = IRQ_PIN_D;
    end else begin
      case (sel)
        2'h0:    pin_code = IRQ_PIN_A;
        2'h1:    pin_code = IRQ_PIN_B;
        2'h2:    pin_code = IRQ_PIN_C;
        default: pin_code = IRQ_PIN_D;
      endcase
    end
  endfunction : pin_code

  // Write decodes; only the line byte and the access register are writable
  assign wr_line       = i_cfg_wr && dw_hit(i_cfg_addr, IRQ_LINE_OFF) && i_cfg_be[IRQ_LINE_OFF[1:0]];
  assign wr_subsys_acc = i_cfg_wr && dw_hit(i_cfg_addr, SUBSYS_ACC_OFF) && (i_cfg_be[3:2] == 2'h3);

  // Subsystem word: only the async global reset clears it, never i_func_rst.
  // A host write through the access register wins over an EEPROM load in the
  // same cycle, since software runs after the loader and expects its value.
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      subsys_ident_word <= SUBSYS_RST;
    end else if (wr_subsys_acc) begin
      subsys_ident_word <= i_cfg_wdata[31:16];
    end else if (i_eep_subsys_we) begin
      subsys_ident_word <= i_eep_subsys_id;
    end
  end

  // Interrupt line, fully writable by the host
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_line_assignment <= IRQ_LINE_RST;
    end else if (i_func_rst) begin
      irq_line_assignment <= IRQ_LINE_RST;
    end else if (wr_line) begin
      irq_line_assignment <= i_cfg_wdata[7:0];
    end
  end

  // Minimum grant: host writes are ignored, only internal logic updates it
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      min_burst_grant <= MIN_GNT_RST;
    end else if (i_func_rst) begin
      min_burst_grant <= MIN_GNT_RST;
    end else if (i_min_gnt_we) begin
      min_burst_grant <= i_min_gnt;
    end
  end

  // Maximum latency: host writes are ignored, EEPROM may reload it
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      max_bus_latency <= MAX_LAT_RST;
    end else if (i_func_rst) begin
      max_bus_latency <= MAX_LAT_RST;
    end else if (i_eep_max_lat_we) begin
      max_bus_latency <= i_eep_max_lat;
    end
  end

  // Forcing inputs toward the core; only interrupt A can be tied
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      force_irq_inputs <= 4'h0;
    end else begin
      force_irq_inputs <= {3'h0, i_tie_all_irq_ctrl};
    end
  end

  // Pin report follows the forcing inputs so both views stay consistent
  assign irq_pin_report = pin_code(force_irq_inputs, i_int_sel);

  // Read mux; unmapped dwords read as zero, reserved bytes too
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (dw_hit(i_cfg_addr, SUBSYS_OFF)) begin
      next_rdata[31:16] = subsys_ident_word;
    end else if (dw_hit(i_cfg_addr, CAP_PTR_OFF)) begin
      next_rdata[7:0] = CAP_PTR_VAL;
    end else if (dw_hit(i_cfg_addr, IRQ_LINE_OFF)) begin
      next_rdata[7:0]   = irq_line_assignment;
      next_rdata[15:8]  = irq_pin_report;
      next_rdata[23:16] = min_burst_grant;
      next_rdata[8*MAX_LAT_LANE +: 8] = max_bus_latency;
    end else if (dw_hit(i_cfg_addr, SUBSYS_ACC_OFF)) begin
      next_rdata[31:16] = subsys_ident_word;
    end
  end

  // Read data and acknowledge, one cycle after the strobe
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_cfg_rdata <= 32'h0000_0000;
      o_cfg_ack   <= 1'b0;
    end else begin
      o_cfg_ack <= i_cfg_rd || i_cfg_wr;
      if (i_cfg_rd) begin
        o_cfg_rdata <= next_rdata;
      end
    end
  end

  // Status outputs
  assign o_force_irq_inputs  = force_irq_inputs;
  assign o_irq_pin_report    = irq_pin_report;
  assign o_subsys_ident_word = subsys_ident_word;

  // Checks, all on the core clock and off while the global reset is low.
  // Expected values come from the register map, not from the read mux, so a
  // lane mix-up in the mux shows up here rather than in host software.
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_read_dw(logic [7:0] off);
    i_cfg_rd && dw_hit(i_cfg_addr, off);
  endsequence

  sequence s_acc_write;
    wr_subsys_acc;
  endsequence

  sequence s_any_strobe;
    i_cfg_rd || i_cfg_wr;
  endsequence

  a_subsys_hold: assert property (
    (!wr_subsys_acc && !i_eep_subsys_we) |=> $stable(subsys_ident_word))
    else $error("subsystem word changed without a load");

  a_subsys_acc_write: assert property (
    s_acc_write |=> subsys_ident_word == $past(i_cfg_wdata[31:16]))
    else $error("access register write not taken");

  a_subsys_readback: assert property (
    s_read_dw(SUBSYS_OFF) |=> o_cfg_ack && o_cfg_rdata[31:16] == $past(subsys_ident_word))
    else $error("subsystem word read wrong");

  a_cap_ptr_read: assert property (
    s_read_dw(CAP_PTR_OFF) |=> o_cfg_rdata == {24'h000000, CAP_PTR_VAL})
    else $error("capability pointer not 44h");

  a_line_write: assert property (
    (wr_line && !i_func_rst) |=> irq_line_assignment == $past(i_cfg_wdata[7:0]))
    else $error("interrupt line write lost");

  a_pin_decode: assert property (
    (force_irq_inputs == 4'h0) |-> irq_pin_report == {6'h00, i_int_sel} + 8'h01)
    else $error("interrupt pin decode wrong");

  a_pin_forced: assert property (
    force_irq_inputs[FORCE_A_BIT] |-> irq_pin_report == IRQ_PIN_A)
    else $error("forced pin not 01h");

  a_tie_all_force: assert property (
    i_tie_all_irq_ctrl[*2] |=> force_irq_inputs == 4'h1 ##0 irq_pin_report == IRQ_PIN_A)
    else $error("tie-all did not force interrupt A");

  a_tie_all_clear: assert property (
    !i_tie_all_irq_ctrl |=> force_irq_inputs == 4'h0)
    else $error("forcing input set without tie-all");

  a_ro_min_gnt: assert property (
    (i_cfg_wr && !i_min_gnt_we && !i_func_rst) |=> $stable(min_burst_grant))
    else $error("host write changed minimum grant");

  a_max_lat_load: assert property (
    (i_eep_max_lat_we && !i_func_rst) |=> max_bus_latency == $past(i_eep_max_lat))
    else $error("maximum latency load wrong");

  a_max_lat_hold: assert property (
    (!i_eep_max_lat_we && !i_func_rst) |=> $stable(max_bus_latency))
    else $error("maximum latency changed without a load");

  a_max_lat_rst: assert property (
    i_func_rst |=> max_bus_latency == MAX_LAT_RST)
    else $error("maximum latency not 04h after function reset");

  // Every strobe is answered exactly one cycle later, writes to read-only bytes
  // included; read data only moves on a read so a late sampler still sees it.
  a_ack_follows: assert property (
    s_any_strobe |=> o_cfg_ack)
    else $error("strobe not acknowledged");

  a_ack_single: assert property (
    !(i_cfg_rd || i_cfg_wr) |=> !o_cfg_ack)
    else $error("acknowledge without a strobe");

  a_rdata_hold: assert property (
    !i_cfg_rd |=> $stable(o_cfg_rdata))
    else $error("read data moved without a read");

  a_write_no_data: assert property (
    (i_cfg_wr && !i_cfg_rd) |=> o_cfg_ack && $stable(o_cfg_rdata))
    else $error("write did not complete cleanly");

  // State at the first edge after the global reset lets go. The disable clause
  // hides the reset itself, so this is the one place the reset state is checked.
  a_reset_values: assert property (
    $rose(i_arst_n) |-> subsys_ident_word == SUBSYS_RST && irq_line_assignment == IRQ_LINE_RST
      && min_burst_grant == MIN_GNT_RST && max_bus_latency == MAX_LAT_RST && force_irq_inputs == 4'h0)
    else $error("state after global reset wrong");

  // Subsystem word: the loader and the access register are its only writers,
  // and the function reset must leave it alone.
  a_subsys_eep_load: assert property (
    (i_eep_subsys_we && !wr_subsys_acc) |=> subsys_ident_word == $past(i_eep_subsys_id))
    else $error("EEPROM load of subsystem word lost");

  a_subsys_ro_write: assert property (
    (i_cfg_wr && dw_hit(i_cfg_addr, SUBSYS_OFF) && !i_eep_subsys_we) |=> $stable(subsys_ident_word))
    else $error("direct write changed subsystem word");

  a_subsys_func_rst: assert property (
    (i_func_rst && !wr_subsys_acc && !i_eep_subsys_we) |=> $stable(subsys_ident_word))
    else $error("function reset touched subsystem word");

  a_acc_partial_be: assert property (
    (i_cfg_wr && dw_hit(i_cfg_addr, SUBSYS_ACC_OFF) && (i_cfg_be[3:2] != 2'h3) && !i_eep_subsys_we)
      |=> $stable(subsys_ident_word))
    else $error("partial access write changed subsystem word");

  a_acc_readback: assert property (
    s_read_dw(SUBSYS_ACC_OFF) |=> o_cfg_rdata == {$past(subsys_ident_word), 16'h0000})
    else $error("access register read wrong");

  // Interrupt dword: each byte lane is read back against the register behind
  // it, since all four registers share one dword address.
  a_line_readback: assert property (
    s_read_dw(IRQ_LINE_OFF) |=> o_cfg_rdata[7:0] == $past(irq_line_assignment)
      && o_cfg_rdata[15:8] == $past(irq_pin_report))
    else $error("line or pin byte read wrong");

  a_grant_readback: assert property (
    s_read_dw(MIN_GNT_OFF) |=> o_cfg_rdata[23:16] == $past(min_burst_grant))
    else $error("minimum grant byte read wrong");

  a_latency_readback: assert property (
    s_read_dw(MAX_LAT_OFF) |=> o_cfg_rdata[31:24] == $past(max_bus_latency))
    else $error("maximum latency byte read wrong");

  a_line_func_rst: assert property (
    i_func_rst |=> irq_line_assignment == IRQ_LINE_RST)
    else $error("interrupt line not FFh after function reset");

  a_line_hold: assert property (
    (!wr_line && !i_func_rst) |=> $stable(irq_line_assignment))
    else $error("interrupt line changed without a write");

  // Minimum grant moves only on the internal update or the function reset;
  // host writes to its lane must fall through.
  a_min_gnt_load: assert property (
    (i_min_gnt_we && !i_func_rst) |=> min_burst_grant == $past(i_min_gnt))
    else $error("minimum grant update lost");

  a_min_gnt_hold: assert property (
    (!i_min_gnt_we && !i_func_rst) |=> $stable(min_burst_grant))
    else $error("minimum grant changed without an update");

  a_min_gnt_rst: assert property (
    i_func_rst |=> min_burst_grant == MIN_GNT_RST)
    else $error("minimum grant not 07h after function reset");

  // Forcing inputs: only interrupt A can ever be forced, one cycle after tie-all,
  // and the reported pin must stay inside the four legal codes.
  a_force_follows_tie: assert property (
    i_tie_all_irq_ctrl |=> force_irq_inputs[FORCE_A_BIT])
    else $error("tie-all did not reach the forcing input");

  a_force_upper_zero: assert property (
    force_irq_inputs[3:1] == 3'h0)
    else $error("forcing input other than A set");

  a_pin_in_range: assert property (
    irq_pin_report >= IRQ_PIN_A && irq_pin_report <= IRQ_PIN_D)
    else $error("interrupt pin code out of range");

  a_tie_set_pin: assert property (
    i_tie_all_irq_ctrl |=> irq_pin_report == IRQ_PIN_A)
    else $error("tie-all did not report interrupt A");

  a_tie_clear_pin: assert property (
    !i_tie_all_irq_ctrl |=> irq_pin_report == {6'h00, i_int_sel} + 8'h01)
    else $error("pin does not follow select after tie-all clears");

  a_pin_follows_sel: assert property (
    (force_irq_inputs == 4'h0 && $stable(force_irq_inputs) && $changed(i_int_sel)) |-> $changed(irq_pin_report))
    else $error("pin did not follow a select change");

endmodule : fmc_cfg_regs

// [test/fmc_host_model.sv]
// Host model: issues single configuration cycles toward the header block.
// Assumes the block acks exactly one cycle after each strobe, on the core clock.
module fmc_host_model (
  // Clock
  input  wire logic        i_core_clk,
  // Configuration cycle toward the block
  output logic             o_cfg_rd,
  output logic             o_cfg_wr,
  output logic [7:0]       o_cfg_addr,
  output logic [3:0]       o_cfg_be,
  output logic [31:0]      o_cfg_wdata,
  // Answer from the block
  input  wire logic [31:0] i_cfg_rdata,
  input  wire logic        i_cfg_ack
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus from time zero
  initial begin
    o_cfg_rd    = 1'b0;
    o_cfg_wr    = 1'b0;
    o_cfg_addr  = 8'h00;
    o_cfg_be    = 4'h0;
    o_cfg_wdata = 32'h0;
  end

  // One strobe cycle; released lines carry inverted junk so stale values never pass
  task automatic access(input logic wr, input logic [7:0] addr, input logic [3:0] be,
                        input logic [31:0] wdata, output logic [31:0] rdata, output logic ack);
    @(negedge i_core_clk);
    o_cfg_rd    = ~wr;
    o_cfg_wr    = wr;
    o_cfg_addr  = addr;
    o_cfg_be    = be;
    o_cfg_wdata = wdata;
    @(negedge i_core_clk);
    ack         = i_cfg_ack;
    rdata       = i_cfg_rdata;
    o_cfg_rd    = 1'b0;
    o_cfg_wr    = 1'b0;
    o_cfg_addr  = ~addr;
    o_cfg_be    = ~be;
    o_cfg_wdata = ~wdata;
  endtask : access
endmodule : fmc_host_model

// [test/test_fmc_cfg_regs.sv]
// Self-checking bench for the flash-media header slice.
// Assumes the host model drives the config port; loaders are strobed here.
module test_fmc_cfg_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import fmc_cfg_pkg::*;

  logic i_core_clk = 1'b0, i_arst_n = 1'b0, i_func_rst = 1'b0;
  logic cfg_rd, cfg_wr, cfg_ack, eep_sub_we = 1'b0, eep_lat_we = 1'b0, gnt_we = 1'b0, tie = 1'b0;
  logic [7:0]  cfg_addr, eep_lat = 8'h00, gnt = 8'h00;
  logic [3:0]  cfg_be, force_irq;
  logic [31:0] cfg_wdata, cfg_rdata;
  logic [15:0] eep_sub = 16'h0, subsys;
  logic [1:0]  int_sel = 2'h0;
  fmc_byte_t   pin;
  int          n_fail = 0, compares = 0;

  // 250 MHz core clock
  always #2 i_core_clk = ~i_core_clk;

  fmc_cfg_regs uut (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_func_rst(i_func_rst),
    .i_cfg_rd(cfg_rd), .i_cfg_wr(cfg_wr), .i_cfg_addr(cfg_addr), .i_cfg_be(cfg_be),
    .i_cfg_wdata(cfg_wdata), .o_cfg_rdata(cfg_rdata), .o_cfg_ack(cfg_ack),
    .i_eep_subsys_we(eep_sub_we), .i_eep_subsys_id(eep_sub), .i_eep_max_lat_we(eep_lat_we),
    .i_eep_max_lat(eep_lat), .i_min_gnt_we(gnt_we), .i_min_gnt(gnt), .i_int_sel(int_sel),
    .i_tie_all_irq_ctrl(tie), .o_force_irq_inputs(force_irq), .o_irq_pin_report(pin),
    .o_subsys_ident_word(subsys));

  fmc_host_model host (.i_core_clk(i_core_clk), .o_cfg_rd(cfg_rd), .o_cfg_wr(cfg_wr),
    .o_cfg_addr(cfg_addr), .o_cfg_be(cfg_be), .o_cfg_wdata(cfg_wdata),
    .i_cfg_rdata(cfg_rdata), .i_cfg_ack(cfg_ack));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic        k;
    host.access(1'b0, a, 4'h0, 32'h0, d, k);
    check("read ack", 32'h1, {31'h0, k});
    check($sformatf("dword %h", a), exp, d);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] wd);
    logic [31:0] d;
    logic        k;
    host.access(1'b1, a, be, wd, d, k);
    check("write ack", 32'h1, {31'h0, k});
  endtask : wr

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  // Watchdog well beyond the sixty-odd cycles the tests need
  initial begin
    #40000;
    n_fail++;
    give_verdict();
  end

  initial begin
    repeat (16) @(negedge i_core_clk);
    i_arst_n = 1'b1;
    rd(8'h2c, 32'h0000_0000);
    rd(8'h34, 32'h0000_0044);
    rd(8'h3c, 32'h0407_01ff);
    $display("test reset values done");
    // Read-only places swallow writes; only the line byte moves
    wr(8'h2e, 4'hf, 32'hffff_ffff);
    wr(8'h34, 4'hf, 32'h0000_0011);
    wr(8'h3c, 4'hf, 32'h1234_5678);
    rd(8'h2c, 32'h0000_0000);
    rd(8'h34, 32'h0000_0044);
    rd(8'h3c, 32'h0407_0178);
    $display("test write access done");
    // Every select code, tie-all clear, then tie-all overriding select
    for (int s = 0; s < 4; s++) begin
      @(negedge i_core_clk) int_sel = 2'(s);
      #1 check("pin", 32'(s + 1), {24'h0, pin});
    end
    check("force", 32'h0, {28'h0, force_irq});
    @(negedge i_core_clk) tie = 1'b1;
    @(negedge i_core_clk) check("force", 32'h1, {28'h0, force_irq});
    check("pin", 32'h1, {24'h0, pin});
    rd(8'h3c, 32'h0407_0178);
    @(negedge i_core_clk) tie = 1'b0;
    @(negedge i_core_clk) check("pin", 32'h4, {24'h0, pin});
    int_sel = 2'h0;
    $display("test interrupt pin done");
    // Loader strobes and the access register
    @(negedge i_core_clk) {eep_sub_we, eep_sub, eep_lat_we, eep_lat} = {1'b1, 16'hbeef, 1'b1, 8'h99};
    {gnt_we, gnt} = {1'b1, 8'h33};
    @(negedge i_core_clk) {eep_sub_we, eep_lat_we, gnt_we} = 3'h0;
    rd(8'h2c, 32'hbeef_0000);
    rd(8'h3c, 32'h9933_0178);
    wr(8'h50, 4'hc, 32'hcafe_1234);
    check("subsys", 32'hcafe, {16'h0, subsys});
    rd(8'h50, 32'hcafe_0000);
    wr(8'h50, 4'h4, 32'h1111_2222);
    check("subsys", 32'hcafe, {16'h0, subsys});
    $display("test loaders done");
    // Function reset spares the subsystem word; global reset clears it
    @(negedge i_core_clk) i_func_rst = 1'b1;
    @(negedge i_core_clk) i_func_rst = 1'b0;
    rd(8'h3c, 32'h0407_01ff);
    rd(8'h2c, 32'hcafe_0000);
    @(negedge i_core_clk) i_arst_n = 1'b0;
    repeat (2) @(negedge i_core_clk);
    i_arst_n = 1'b1;
    rd(8'h2c, 32'h0000_0000);
    $display("test resets done");
    give_verdict();
  end
endmodule : test_fmc_cfg_regs
